// >>> test/fprfa_pipe_model.sv
`timescale 1ns/1ps
module fprfa_pipe_model (
  input wire logic clock, // clock
  input wire logic rst, // reset
  input wire logic raiseTrap, // trap pulse
  output int trapCount // traps taken
);
  always_ff @(posedge clock) trapCount <= rst ? 0 : trapCount + int'(raiseTrap);
endmodule

// >>> test/fprfa_regfile_props.sv
`timescale 1ns/1ps
module fprfa_regfile_props
  import fprfa_pkg::*;
(
  input wire logic clock, // clock
  input wire logic rst, // reset
  input wire fprfa_req_t regReq, // access
  input wire fprfa_cc_req_t ccReq, // code access
  input wire logic csWrite, // word load
  input wire logic trapCheck, // check
  input wire logic readValid, // read pulse
  input wire logic ccReadValue, // code value
  input wire logic ccReadValid, // code pulse
  input wire logic raiseTrap, // trap
  input wire logic [CsW-1:0] fpCtrlStatusWord // word
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [4:0] ccBit;
  logic pend;
  assign ccBit = ccReq.flag_index == 3'h0 ? 5'h17 : 5'h18 + 5'(ccReq.flag_index);
  assign pend = fpCtrlStatusWord[17] | (|(fpCtrlStatusWord[16:12] & fpCtrlStatusWord[11:7]));
  sequence s_ccWr;
    ccReq.valid && ccReq.write && !csWrite;
  endsequence
  property p_unimpl; trapCheck && fpCtrlStatusWord[17] |=> raiseTrap; endproperty
  property p_enab; trapCheck && pend |=> raiseTrap; endproperty
  property p_noTrap; !(trapCheck && pend) |=> !raiseTrap; endproperty
  property p_ccRd;
    ccReq.valid && !ccReq.write |=> ccReadValid && ccReadValue == $past(fpCtrlStatusWord[ccBit]);
  endproperty
  property p_ccWr;
    s_ccWr ##0 !(trapCheck && pend) |=> fpCtrlStatusWord[$past(ccBit)] == $past(ccReq.value);
  endproperty
  property p_abort; s_ccWr ##0 trapCheck && pend |=> $stable(fpCtrlStatusWord); endproperty
  property p_rd; regReq.valid && !regReq.write |=> readValid; endproperty
  a_unimpl: assert property (p_unimpl) else $error("no trap on unimplemented");
  a_enab: assert property (p_enab) else $error("no trap on enabled cause");
  a_noTrap: assert property (p_noTrap) else $error("spurious trap");
  a_ccRd: assert property (p_ccRd) else $error("code read wrong");
  a_ccWr: assert property (p_ccWr) else $error("code write wrong");
  a_abort: assert property (p_abort) else $error("write not aborted");
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_trapCause; raiseTrap |-> $past(trapCheck && pend); endproperty
  a_trapCause: assert property (p_trapCause) else $error("trap without cause");
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  import fprfa_pkg::*;
  logic clock = 1'b0, rst = 1'b1, narrowRegfileMode = 1'b0, csWrite = 1'b0, trapCheck = 1'b0;
  fprfa_req_t regReq = '0;
  fprfa_cc_req_t ccReq = '0;
  logic [CsW-1:0] csWriteData = '0, cs = '0, fpCtrlStatusWord;
  logic [DblW-1:0] readData, trapRegExp = '0;
  logic readValid, ccReadValue, ccReadValid, raiseTrap;
  int bad_count = 0, tests_run = 0, trapCount;
  always #2 clock = ~clock;
  fprfa_regfile i_dut(.clock, .rst, .narrowRegfileMode, .regReq, .ccReq, .csWrite,
    .csWriteData, .trapCheck, .readData, .readValid, .ccReadValue, .ccReadValid,
    .raiseTrap, .fpCtrlStatusWord);
  fprfa_pipe_model i_pipe(.clock, .rst, .raiseTrap, .trapCount);
  task chk(input logic [DblW-1:0] got, input logic [DblW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [4:0] i, input fprfa_fmt_t f, input logic [63:0] d);
    @(negedge clock) regReq = '{1'b1, w, i, f, d};
    @(negedge clock) regReq.valid = 1'b0;
  endtask
  task rd(input logic [4:0] i, input fprfa_fmt_t f, input logic [63:0] e);
    acc(1'b0, i, f, 64'h0);
    chk(64'(readValid), 64'h1);
    chk(readData, e);
  endtask
  task cc(input logic w, input logic [2:0] i, input logic v);
    @(negedge clock) ccReq = '{1'b1, w, i, v};
    @(negedge clock) ccReq.valid = 1'b0;
  endtask
  task trap(input logic [CsW-1:0] word, input logic e);
    @(negedge clock) begin
      csWrite = 1'b1;
      csWriteData = word;
    end
    @(negedge clock) begin
      csWrite = 1'b0;
      trapCheck = 1'b1;
      ccReq = '{1'b1, 1'b1, 3'h0, 1'b1};
      regReq = '{1'b1, 1'b1, 5'h8, FPRFA_FMT_S, 64'(word)};
    end
    @(negedge clock) begin
      trapCheck = 1'b0;
      ccReq.valid = 1'b0;
      regReq.valid = 1'b0;
    end
    chk(64'(raiseTrap), 64'(e));
    chk(64'(fpCtrlStatusWord), 64'(e ? word : word | 32'h0080_0000));
    if (!e) trapRegExp = 64'(word);
    rd(5'h8, FPRFA_FMT_S, trapRegExp);
  endtask
  task report_and_stop;
    $display("mismatches %0d checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    acc(1'b1, 5'h2, FPRFA_FMT_D, 64'h1122_3344_5566_7788);
    rd(5'h2, FPRFA_FMT_D, 64'h1122_3344_5566_7788);
    acc(1'b1, 5'h3, FPRFA_FMT_PS, 64'hfedc_ba98_7654_3210);
    rd(5'h3, FPRFA_FMT_PS, 64'hfedc_ba98_7654_3210);
    narrowRegfileMode = 1'b1;
    acc(1'b1, 5'h4, FPRFA_FMT_UW, 64'h0000_aaaa_0000_0011);
    acc(1'b1, 5'h5, FPRFA_FMT_UW, 64'h22);
    rd(5'h4, FPRFA_FMT_UD, 64'h0000_0022_0000_0011);
    acc(1'b1, 5'h4, FPRFA_FMT_L, 64'h5);
    rd(5'h4, FPRFA_FMT_W, 64'h0000_aaaa_0000_0011);
    acc(1'b1, 5'h6, FPRFA_FMT_D, 64'h33_0000_0044);
    acc(1'b1, 5'h7, FPRFA_FMT_D, 64'h9);
    rd(5'h6, FPRFA_FMT_D, 64'h0000_0033_0000_0044);
    for (int i = 0; i < CcCount; i++) begin
      cc(1'b1, 3'(i), 1'b1);
      cc(1'b0, 3'(i), 1'b0);
      chk(64'(ccReadValue), 64'h1);
      cs[i == 0 ? CsCc0Bit : CsCcBase + i] = 1'b1;
      chk(64'(fpCtrlStatusWord), 64'(cs));
    end
    cc(1'b1, 3'h3, 1'b0);
    cc(1'b0, 3'h3, 1'b1);
    chk(64'(ccReadValue), 64'h0);
    cs[CsCcBase + 3] = 1'b0;
    chk(64'(fpCtrlStatusWord), 64'(cs));
    trap(32'h0002_0000, 1'b1);
    trap(32'h0000_1080, 1'b1);
    trap(32'h0001_f000, 1'b0);
    chk(64'(trapCount), 64'h2);
    @(negedge clock) rst = 1'b1;
    @(negedge clock) rst = 1'b0;
    chk(64'(fpCtrlStatusWord), 64'(CsReset));
    chk(64'(ccReadValue), 64'h0);
    rd(5'h2, FPRFA_FMT_D, RegReset);
    report_and_stop();
  end
endmodule
bind fprfa_regfile fprfa_regfile_props i_props(.clock, .rst, .regReq, .ccReq, .csWrite,
  .trapCheck, .readValid, .ccReadValue, .ccReadValid, .raiseTrap, .fpCtrlStatusWord);

// >>> verilog/fprfa_pkg.sv
package fprfa_pkg;
  localparam int NumRegs = 32;
  localparam int IdxW = 5;
  localparam int WordW = 32;
  localparam int DblW = 64;
  localparam int CsW = 32;
  localparam int CcCount = 8;
  localparam int CcIdxW = 3;
  localparam int CsUnimplBit = 17;
  localparam int CsCauseLo = 12;
  localparam int CsEnableLo = 7;
  localparam int CsFieldW = 5;
  localparam int CsCc0Bit = 23;
  localparam int CsCcBase = 24;
  localparam logic [CsW-1:0] CsReset = 32'h0000_0000;
  localparam logic [DblW-1:0] RegReset = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    FPRFA_FMT_S = 3'h0,
    FPRFA_FMT_D = 3'h1,
    FPRFA_FMT_W = 3'h2,
    FPRFA_FMT_L = 3'h3,
    FPRFA_FMT_PS = 3'h4,
    FPRFA_FMT_UW = 3'h5,
    FPRFA_FMT_UD = 3'h6
  } fprfa_fmt_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [IdxW-1:0] reg_idx;
    fprfa_fmt_t fmt;
    logic [DblW-1:0] data;
  } fprfa_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [CcIdxW-1:0] flag_index;
    logic value;
  } fprfa_cc_req_t;
endpackage

// >>> verilog/fprfa_regfile.sv
`timescale 1ns/1ps
// Operation
// - narrow mode doubleword read pairs even/odd halves
// - narrow odd-register doubleword access is unpredictable
// - narrow mode long/paired stores unpredictable
// - unimplemented-operation cause always raises trap
// - enabled cause bits raise trap
// - code 0 bit 23, others 24+index
// - trap aborts the instruction's write
module fprfa_regfile
  import fprfa_pkg::*;
#(
  parameter int Regs = NumRegs
) (
  input wire logic clock, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic narrowRegfileMode, // 32-bit register mode
  input wire fprfa_req_t regReq, // formatted register access
  input wire fprfa_cc_req_t ccReq, // condition code access
  input wire logic csWrite, // load control/status word
  input wire logic [CsW-1:0] csWriteData, // new control/status word
  input wire logic trapCheck, // run exception check this cycle
  output logic [DblW-1:0] readData, // formatted read value
  output logic readValid, // readData valid
  output logic ccReadValue, // condition code read value
  output logic ccReadValid, // ccReadValue valid
  output logic raiseTrap, // exception pulse
  output logic [CsW-1:0] fpCtrlStatusWord // current control/status word
);
  typedef struct packed {
    logic [Regs-1:0][DblW-1:0] regs;
    logic [CsW-1:0] cs;
    logic [DblW-1:0] rdata;
    logic rvalid;
    logic ccVal;
    logic ccValid;
    logic trap;
  } fprfa_state_t;

  fprfa_state_t state_q, state_d;
  logic trapPending;
  logic abortNow;

  // request decode; only the two writes pass the abort gate
  logic regRead;
  logic regWrite;
  logic ccRead;
  logic ccWrite;

  // next-value candidates from the formatted access functions and the word load
  logic [DblW-1:0] regReadValue;
  logic [Regs-1:0][DblW-1:0] regsAfterWrite;
  logic [CsW-1:0] csAfterLoad;
  logic [CsW-1:0] csAfterCode;
  logic ccReadBit;

  function automatic logic [4:0] cc_bit(input logic [CcIdxW-1:0] idx);
    if (idx == '0) begin
      cc_bit = 5'(CsCc0Bit);
    end else begin
      cc_bit = 5'(CsCcBase + int'(idx));
    end
  endfunction

  function automatic logic is_dbl(input fprfa_fmt_t f);
    is_dbl = (f == FPRFA_FMT_D) || (f == FPRFA_FMT_UD);
  endfunction

  function automatic logic is_lps(input fprfa_fmt_t f);
    is_lps = (f == FPRFA_FMT_L) || (f == FPRFA_FMT_PS);
  endfunction

  function automatic logic is_word(input fprfa_fmt_t f);
    is_word = (f == FPRFA_FMT_S) || (f == FPRFA_FMT_W) || (f == FPRFA_FMT_UW);
  endfunction

  // second register of an even/odd pair; wraps at the top of the bank
  function automatic logic [IdxW-1:0] pair_idx(input logic [IdxW-1:0] idx);
    pair_idx = idx + IdxW'(1'b1);
  endfunction

  // formats that pair two registers in the 32-bit register mode
  function automatic logic is_paired(input fprfa_fmt_t f, input logic narrow);
    is_paired = narrow && is_dbl(f);
  endfunction

  // formatted read of one register or of an even/odd pair
  function automatic logic [DblW-1:0] read_formatted_reg(
    input logic [Regs-1:0][DblW-1:0] bank,
    input logic [IdxW-1:0] idx,
    input fprfa_fmt_t f,
    input logic narrow
  );
    logic [IdxW-1:0] nxt;
    logic [DblW-1:0] value;
    nxt = pair_idx(idx);
    if (is_paired(f, narrow)) begin
      // an odd index is unpredictable; the same pairing is returned
      value = {bank[nxt][WordW-1:0], bank[idx][WordW-1:0]};
    end else if (is_dbl(f) || is_lps(f)) begin
      value = bank[idx];
    end else if (is_word(f)) begin
      value = bank[idx];
    end else begin
      value = RegReset;
    end
    read_formatted_reg = value;
  endfunction

  // formatted store; stores the mode leaves unpredictable are dropped
  function automatic logic [Regs-1:0][DblW-1:0] write_formatted_reg(
    input logic [Regs-1:0][DblW-1:0] bank,
    input logic [IdxW-1:0] idx,
    input fprfa_fmt_t f,
    input logic narrow,
    input logic [DblW-1:0] value
  );
    logic [IdxW-1:0] nxt;
    logic [Regs-1:0][DblW-1:0] result;
    nxt = pair_idx(idx);
    result = bank;
    if (is_paired(f, narrow)) begin
      // odd-register pairs are dropped rather than guessed at
      if (!idx[0]) begin
        result[idx] = {{WordW{1'b0}}, value[WordW-1:0]};
        result[nxt] = {{WordW{1'b0}}, value[DblW-1:WordW]};
      end
    end else if (is_lps(f) && narrow) begin
      result[idx] = bank[idx];
    end else begin
      result[idx] = value;
    end
    write_formatted_reg = result;
  endfunction

  function automatic logic cond_code_read(
    input logic [CsW-1:0] word,
    input logic [CcIdxW-1:0] idx
  );
    cond_code_read = word[cc_bit(idx)];
  endfunction

  // only the code's own bit moves; every other bit is kept
  function automatic logic [CsW-1:0] cond_code_write(
    input logic [CsW-1:0] word,
    input logic [CcIdxW-1:0] idx,
    input logic value
  );
    logic [CsW-1:0] result;
    result = word;
    result[cc_bit(idx)] = value;
    cond_code_write = result;
  endfunction

  fprfa_trap_check u_check (
    .ctrlStatus(state_q.cs),
    .trapPending(trapPending)
  );

  // the check sees the word as it stood before a same-cycle load
  assign abortNow = trapCheck & trapPending;
  assign regRead = regReq.valid & ~regReq.write;
  assign regWrite = regReq.valid & regReq.write & ~abortNow;
  assign ccRead = ccReq.valid & ~ccReq.write;
  assign ccWrite = ccReq.valid & ccReq.write & ~abortNow;

  assign regReadValue = read_formatted_reg(state_q.regs, regReq.reg_idx, regReq.fmt,
    narrowRegfileMode);
  assign regsAfterWrite = write_formatted_reg(state_q.regs, regReq.reg_idx, regReq.fmt,
    narrowRegfileMode, regReq.data);
  // a word load lands first; a same-cycle code write then overrides its bit
  assign csAfterLoad = csWrite ? csWriteData : state_q.cs;
  assign csAfterCode = cond_code_write(csAfterLoad, ccReq.flag_index, ccReq.value);
  assign ccReadBit = cond_code_read(state_q.cs, ccReq.flag_index);

  always_comb begin
    state_d = state_q;
    // pulses drop unless a new request is taken
    state_d.rvalid = regRead;
    state_d.ccValid = ccRead;
    state_d.trap = abortNow;
    state_d.cs = csAfterLoad;
    if (regRead) begin
      state_d.rdata = regReadValue;
    end
    if (regWrite) begin
      state_d.regs = regsAfterWrite;
    end
    if (ccRead) begin
      state_d.ccVal = ccReadBit;
    end
    if (ccWrite) begin
      // code write wins over the loaded word for its own bit
      state_d.cs = csAfterCode;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q.regs <= '0;
      state_q.cs <= CsReset;
      state_q.rdata <= RegReset;
      state_q.rvalid <= 1'b0;
      state_q.ccVal <= 1'b0;
      state_q.ccValid <= 1'b0;
      state_q.trap <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign readData = state_q.rdata;
  assign readValid = state_q.rvalid;
  assign ccReadValue = state_q.ccVal;
  assign ccReadValid = state_q.ccValid;
  assign raiseTrap = state_q.trap;
  assign fpCtrlStatusWord = state_q.cs;
endmodule

// >>> verilog/fprfa_trap_check.sv
`timescale 1ns/1ps
module fprfa_trap_check
  import fprfa_pkg::*;
(
  input wire logic [CsW-1:0] ctrlStatus, // control/status word
  output logic trapPending // enabled exception present
);
  always_comb begin
    trapPending = ctrlStatus[CsUnimplBit] |
      (|(ctrlStatus[CsCauseLo +: CsFieldW] & ctrlStatus[CsEnableLo +: CsFieldW]));
  end
endmodule
